// ===== hw/flash_ctrl_defines.svh
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

// register byte offsets
`define OFS_OPERATION_CODE 8'h00
`define OFS_VECTOR_VECTORS_TO_RAM_CONFIG 8'h04
`define OFS_MASKED_EVENT_STATUS 8'h08
`define OFS_EVENT_MASK 8'h0C
`define OFS_RAW_EVENT_STATUS 8'h10
`define OFS_ARRAY_SIZE 8'h14
`define OFS_PROGRAM_ADDRESS 8'h18
`define OFS_PROGRAM_WORD_0 8'h40
`define OFS_PROGRAM_WORD_1 8'h44
`define OFS_PROGRAM_WORD_2 8'h48
`define OFS_PROGRAM_WORD_3 8'h4C

// configuration field positions
`define BIT_VECTORS_TO_RAM 1
`define BIT_VECTORS_TO_NVM 3

// event field positions
`define EVT_W 6
`define EVT_OP_COMPLETE 0
`define EVT_OP_ACCEPTED 1
`define EVT_OP_WHILE_BUSY 2
`define EVT_BAD_OPCODE 3
`define EVT_ARRAY_CHECK_OK 4
`define EVT_ARRAY_ASLEEP 5

// reset values
`define RST_OPERATION_CODE 32'h0000_0000
`define RST_EVENT_MASK 6'h3F
`define RST_PROGRAM_ADDRESS 32'h0000_0000
`define RST_PROGRAM_WORD 32'h0FFF_FFFF
`define VAL_ARRAY_SIZE 32'h0000_FFFF
`define VAL_ALL_ONES 32'hFFFF_FFFF

// operation codes
`define OPC_PAGE_ERASE 32'h0000_0011
`define OPC_FULL_ARRAY_ERASE 32'h0000_0022
`define OPC_WORD_PROGRAM 32'h0000_0033
`define OPC_MULTI_WORD_PROGRAM 32'h0000_00CC

// burst geometry
`define BURST_WORDS 4

`endif

// ===== hw/flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;

  // sequencer states, gray along idle-issue-wait-next-finish
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ISSUE = 3'h1,
    ST_WAIT = 3'h3,
    ST_NEXT = 3'h2,
    ST_FINISH = 3'h6
  } seq_state_e;

  // operation presented to the array
  typedef enum logic [1:0] {
    OP_PAGE_ERASE = 2'h0,
    OP_FULL_ERASE = 2'h1,
    OP_PROGRAM = 2'h2
  } array_op_e;

  // operation kind latched at launch
  typedef enum logic [1:0] {
    KIND_PAGE_ERASE = 2'h0,
    KIND_FULL_ERASE = 2'h1,
    KIND_WORD = 2'h2,
    KIND_BURST = 2'h3
  } op_kind_e;

endpackage : flash_ctrl_pkg
`default_nettype wire

// ===== hw/event_flags.sv
`default_nettype none
`include "flash_ctrl_defines.svh"
module event_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and software clears
  input wire logic [`EVT_W-1:0] set,
  input wire logic [`EVT_W-1:0] clr,
  input wire logic [`EVT_W-1:0] mask,
  // views
  output logic [`EVT_W-1:0] raw,
  output logic [`EVT_W-1:0] masked
);

  genvar i;
  generate
    for (i = 0; i < `EVT_W; i++) begin : g_flag
      // set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          raw[i] <= 1'b0;
        end else if (set[i]) begin
          raw[i] <= 1'b1;
        end else if (clr[i]) begin
          raw[i] <= 1'b0;
        end
      end

      flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        clr[i] && !set[i] |=> !raw[i]) else $error("flag not cleared by write of one");
      flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        set[i] |=> raw[i] [*2] or (raw[i] ##1 $past(clr[i]))) else $error("flag lost");
    end
  endgenerate

  assign masked = raw & mask;

endmodule : event_flags
`default_nettype wire

// ===== hw/word_skip_map.sv
`default_nettype none
`include "flash_ctrl_defines.svh"
module word_skip_map (
  // packed program words, word 0 in the low bits
  input wire logic [32*`BURST_WORDS-1:0] words,
  // one per word that needs no programming
  output logic [`BURST_WORDS-1:0] skip
);

  genvar i;
  generate
    for (i = 0; i < `BURST_WORDS; i++) begin : g_word
      assign skip[i] = (words[32*i +: 32] == `VAL_ALL_ONES);
    end
  endgenerate

endmodule : word_skip_map
`default_nettype wire

// ===== hw/flash_ctrl_register_interface.sv
// Functional notes
// - 32-bit operation code register, reset zero
// - config bit 1 maps vectors to RAM
// - config bit 3 maps vectors to flash
// - status bit 0 completion, write one clears
// - status bit 1 accepted, write one clears
// - status bit 2 opcode while busy
// - status bit 3 unrecognised opcode
// - status bit 4 whole-array check succeeded
// - status bit 5 array not ready
// - mask bits 5..0, reset ones
// - raw event view, unmasked, reset zero
// - size register reads 0xFFFF
// - program address auto-increments
// - four program words, reset as printed
// - opcodes 0x11, 0x22, 0x33, 0xCC
// - status offset shows masked events
// - burst skips all-ones words
// - erased region reads all ones
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_ctrl_register_interface
  import flash_ctrl_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // flash array
  output logic FL_REQ,
  output array_op_e FL_OP,
  output logic [31:0] FL_ADDR,
  output logic [31:0] FL_WDATA,
  input wire logic FL_DONE,
  input wire logic FL_READY,
  input wire logic FL_CHECK_OK,
  // vector table placement
  output logic VECTORS_TO_RAM,
  output logic VECTORS_TO_NVM
);

  logic setup;
  logic wr_en;
  logic [31:0] op_code;
  logic [`EVT_W-1:0] mask;
  logic [`EVT_W-1:0] raw;
  logic [`EVT_W-1:0] masked;
  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] evt_clr;
  logic [31:0] address;
  logic [31:0] data [`BURST_WORDS];
  logic [32*`BURST_WORDS-1:0] data_flat;
  logic [`BURST_WORDS-1:0] skip;
  logic [1:0] slot;
  seq_state_e state;
  op_kind_e kind;
  logic ready_q;
  logic cmd_wr;
  logic busy;
  logic valid_op;
  logic start;
  logic slot_skipped;
  logic inc_addr;
  logic is_prog;
  logic [31:0] rd_mux;
  logic mapped;

  // apb handshake: one wait-free access after the setup cycle
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  // read decode, sampled in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      `OFS_OPERATION_CODE: rd_mux = op_code;
      `OFS_VECTOR_VECTORS_TO_RAM_CONFIG: begin
        rd_mux[`BIT_VECTORS_TO_RAM] = VECTORS_TO_RAM;
        rd_mux[`BIT_VECTORS_TO_NVM] = VECTORS_TO_NVM;
      end
      `OFS_MASKED_EVENT_STATUS: rd_mux[`EVT_W-1:0] = masked;
      `OFS_EVENT_MASK: rd_mux[`EVT_W-1:0] = mask;
      `OFS_RAW_EVENT_STATUS: rd_mux[`EVT_W-1:0] = raw;
      `OFS_ARRAY_SIZE: rd_mux = `VAL_ARRAY_SIZE;
      `OFS_PROGRAM_ADDRESS: rd_mux = address;
      `OFS_PROGRAM_WORD_0: rd_mux = data[0];
      `OFS_PROGRAM_WORD_1: rd_mux = data[1];
      `OFS_PROGRAM_WORD_2: rd_mux = data[2];
      `OFS_PROGRAM_WORD_3: rd_mux = data[3];
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= ~mapped;
    end else begin
      PSLVERR <= 1'b0;
    end
  end

  // operation code and launch checks
  assign cmd_wr = wr_en & (PADDR == `OFS_OPERATION_CODE);
  assign busy = (state != ST_IDLE);
  assign valid_op = (PWDATA == `OPC_PAGE_ERASE) | (PWDATA == `OPC_FULL_ARRAY_ERASE) |
                    (PWDATA == `OPC_WORD_PROGRAM) | (PWDATA == `OPC_MULTI_WORD_PROGRAM);
  assign start = cmd_wr & ~busy & valid_op;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      op_code <= `RST_OPERATION_CODE;
    end else if (cmd_wr & ~busy) begin
      op_code <= PWDATA;
    end
  end

  // vector table placement; reserved bits are not stored
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      VECTORS_TO_RAM <= 1'b0;
      VECTORS_TO_NVM <= 1'b0;
    end else if (wr_en & (PADDR == `OFS_VECTOR_VECTORS_TO_RAM_CONFIG)) begin
      VECTORS_TO_RAM <= PWDATA[`BIT_VECTORS_TO_RAM];
      VECTORS_TO_NVM <= PWDATA[`BIT_VECTORS_TO_NVM];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask <= `RST_EVENT_MASK;
    end else if (wr_en & (PADDR == `OFS_EVENT_MASK)) begin
      mask <= PWDATA[`EVT_W-1:0];
    end
  end

  // program words
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int k = 0; k < `BURST_WORDS; k++) begin
        data[k] <= `RST_PROGRAM_WORD;
      end
    end else if (wr_en & (PADDR >= `OFS_PROGRAM_WORD_0) & (PADDR <= `OFS_PROGRAM_WORD_3) &
                 (PADDR[1:0] == 2'h0)) begin
      data[PADDR[3:2]] <= PWDATA;
    end
  end

  generate
    for (genvar w = 0; w < `BURST_WORDS; w++) begin : g_flat
      assign data_flat[32*w +: 32] = data[w];
    end
  endgenerate

  word_skip_map word_skip_map_inst (
    .words(data_flat),
    .skip(skip)
  );

  // program address: the sequencer's advance wins over a software write
  assign is_prog = (kind == KIND_WORD) | (kind == KIND_BURST);
  assign slot_skipped = (state == ST_ISSUE) & (kind == KIND_BURST) & skip[slot];
  assign inc_addr = slot_skipped | ((state == ST_WAIT) & FL_DONE & is_prog);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      address <= `RST_PROGRAM_ADDRESS;
    end else if (inc_addr) begin
      address <= address + 32'h0000_0001;
    end else if (wr_en & (PADDR == `OFS_PROGRAM_ADDRESS)) begin
      address <= PWDATA;
    end
  end

  // sequencer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      kind <= KIND_PAGE_ERASE;
      slot <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_ISSUE;
            slot <= 2'h0;
            case (PWDATA)
              `OPC_PAGE_ERASE: kind <= KIND_PAGE_ERASE;
              `OPC_FULL_ARRAY_ERASE: kind <= KIND_FULL_ERASE;
              `OPC_WORD_PROGRAM: kind <= KIND_WORD;
              default: kind <= KIND_BURST;
            endcase
          end
        end
        ST_ISSUE: begin
          if (slot_skipped) begin
            state <= (slot == 2'h3) ? ST_FINISH : ST_NEXT;
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (FL_DONE) begin
            state <= ((kind == KIND_BURST) && (slot != 2'h3)) ? ST_NEXT : ST_FINISH;
          end
        end
        ST_NEXT: begin
          slot <= slot + 2'h1;
          state <= ST_ISSUE;
        end
        ST_FINISH: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // array request, held until the array reports done
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FL_REQ <= 1'b0;
      FL_OP <= OP_PAGE_ERASE;
      FL_ADDR <= 32'h0000_0000;
      FL_WDATA <= `VAL_ALL_ONES;
    end else if ((state == ST_ISSUE) & ~slot_skipped) begin
      FL_REQ <= 1'b1;
      FL_ADDR <= address;
      case (kind)
        KIND_PAGE_ERASE: begin
          FL_OP <= OP_PAGE_ERASE;
          FL_WDATA <= `VAL_ALL_ONES;
        end
        KIND_FULL_ERASE: begin
          FL_OP <= OP_FULL_ERASE;
          FL_WDATA <= `VAL_ALL_ONES;
        end
        default: begin
          FL_OP <= OP_PROGRAM;
          FL_WDATA <= data[slot];
        end
      endcase
    end else if ((state == ST_WAIT) & FL_DONE) begin
      FL_REQ <= 1'b0;
    end
  end

  // array readiness edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= FL_READY;
    end
  end

  // event sources and write-one clears from either view
  always_comb begin
    evt_set = '0;
    evt_set[`EVT_OP_COMPLETE] = (state == ST_FINISH);
    evt_set[`EVT_OP_ACCEPTED] = start;
    evt_set[`EVT_OP_WHILE_BUSY] = cmd_wr & busy;
    evt_set[`EVT_BAD_OPCODE] = cmd_wr & ~busy & ~valid_op;
    evt_set[`EVT_ARRAY_CHECK_OK] = FL_CHECK_OK;
    evt_set[`EVT_ARRAY_ASLEEP] = ready_q & ~FL_READY;
  end

  assign evt_clr = (wr_en & ((PADDR == `OFS_MASKED_EVENT_STATUS) |
                    (PADDR == `OFS_RAW_EVENT_STATUS))) ? PWDATA[`EVT_W-1:0] : '0;

  event_flags event_flags_inst (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .set(evt_set),
    .clr(evt_clr),
    .mask(mask),
    .raw(raw),
    .masked(masked)
  );

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  opcode_store_a: assert property (
    cmd_wr && !busy |=> op_code == $past(PWDATA)) else $error("opcode not stored");
  vec_ram_a: assert property (
    wr_en && PADDR == `OFS_VECTOR_VECTORS_TO_RAM_CONFIG |=> VECTORS_TO_RAM == $past(PWDATA[1]))
    else $error("ram placement bit wrong");
  vec_nvm_a: assert property (
    wr_en && PADDR == `OFS_VECTOR_VECTORS_TO_RAM_CONFIG |=> VECTORS_TO_NVM == $past(PWDATA[3]))
    else $error("flash placement bit wrong");
  done_flag_a: assert property (
    state == ST_FINISH |=> raw[`EVT_OP_COMPLETE] && state == ST_IDLE)
    else $error("completion not flagged");
  accept_flow_a: assert property (
    start |=> raw[`EVT_OP_ACCEPTED] && state == ST_ISSUE) else $error("launch not flagged");
  busy_err_a: assert property (
    cmd_wr && busy |=> raw[`EVT_OP_WHILE_BUSY] && op_code == $past(op_code))
    else $error("busy write not flagged");
  bad_op_a: assert property (
    cmd_wr && !busy && !valid_op
    |=> raw[`EVT_BAD_OPCODE] && state == ST_IDLE ##1 state == ST_IDLE)
    else $error("bad opcode launched or not flagged");
  check_ok_a: assert property (
    FL_CHECK_OK |=> raw[`EVT_ARRAY_CHECK_OK]) else $error("check result lost");
  asleep_a: assert property (
    $fell(FL_READY) |=> raw[`EVT_ARRAY_ASLEEP]) else $error("sleep not flagged");
  masked_read_a: assert property (
    setup && !PWRITE && PADDR == `OFS_MASKED_EVENT_STATUS
    |=> PRDATA == {26'h0, $past(raw) & $past(mask)}) else $error("masked view wrong");
  raw_read_a: assert property (
    setup && !PWRITE && PADDR == `OFS_RAW_EVENT_STATUS |=> PRDATA == {26'h0, $past(raw)})
    else $error("raw view wrong");
  size_read_a: assert property (
    setup && !PWRITE && PADDR == `OFS_ARRAY_SIZE |=> PREADY && PRDATA == 32'h0000_FFFF)
    else $error("size value wrong");
  addr_inc_a: assert property (
    state == ST_WAIT && FL_DONE && is_prog |=> address == $past(address) + 32'h0000_0001)
    else $error("address did not advance");
  word_skip_a: assert property (
    slot_skipped |=> !FL_REQ && state != ST_WAIT) else $error("all-ones word programmed");
  erase_fill_a: assert property (
    FL_REQ && FL_OP != OP_PROGRAM |-> FL_WDATA == 32'hFFFF_FFFF) else $error("erase fill wrong");
  no_launch_a: assert property (
    cmd_wr && (busy || !valid_op) |=> !$rose(raw[`EVT_OP_ACCEPTED]))
    else $error("rejected opcode launched");

endmodule : flash_ctrl_register_interface
`default_nettype wire

// ===== verif/flash_array_model.sv
`default_nettype none
module flash_array_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the controller
  input wire logic fl_req,
  output logic fl_done,
  // bench controls
  input wire logic [3:0] lat,
  input wire logic awake,
  input wire logic check,
  // array state
  output logic fl_ready,
  output logic fl_check_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic served;

  // one done pulse per request, lat+1 cycles after the request is first sampled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      served <= 1'b0;
      fl_done <= 1'b0;
    end else begin
      fl_done <= 1'b0;
      if (!fl_req) begin
        cnt <= 4'h0;
        served <= 1'b0;
      end else if (!served) begin
        if (cnt == lat) begin
          fl_done <= 1'b1;
          served <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  assign fl_ready = awake;
  assign fl_check_ok = check;
endmodule : flash_array_model
`default_nettype wire

// ===== verif/flash_ctrl_register_interface_test.sv
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_ctrl_register_interface_test
  import flash_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, prev_req;
  logic fl_req, fl_done, fl_ready, fl_check_ok, to_ram, to_nvm, awake, check_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fl_addr, fl_wdata, rd;
  logic [3:0] lat;
  array_op_e fl_op;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [65:0] reqs[$];
  logic [7:0] ofs[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40, 8'h44,
    8'h48, 8'h4C};
  logic [31:0] rst_val[11] = '{32'h0, 32'h0, 32'h0, 32'h0000_003F, 32'h0, 32'h0000_FFFF,
    32'h0, `RST_PROGRAM_WORD, `RST_PROGRAM_WORD, `RST_PROGRAM_WORD, `RST_PROGRAM_WORD};
  logic [31:0] cfg_val[4] = '{32'h0000_0002, 32'h0000_0008, 32'h0000_000A, 32'h0};
  logic [31:0] bw[4] = '{32'h0000_000A, 32'hFFFF_FFFF, 32'h0000_000C, 32'h0000_000D};

  flash_ctrl_register_interface flash_ctrl_register_interface_inst (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FL_REQ(fl_req), .FL_OP(fl_op), .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata),
    .FL_DONE(fl_done), .FL_READY(fl_ready), .FL_CHECK_OK(fl_check_ok),
    .VECTORS_TO_RAM(to_ram), .VECTORS_TO_NVM(to_nvm));

  flash_array_model flash_array_model_inst (
    .clk(ref_clk), .rst_n(rst_n), .fl_req(fl_req), .fl_done(fl_done), .lat(lat),
    .awake(awake), .check(check_pulse), .fl_ready(fl_ready), .fl_check_ok(fl_check_ok));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // request log and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (fl_req === 1'b1 && prev_req !== 1'b1) begin
      reqs.push_back({fl_op, fl_addr, fl_wdata});
    end
    prev_req = fl_req;
    if (cycles == 20000) begin
      err_count++;
      finish_test;
    end
  end

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    check("access cycles", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask : rd_chk

  // poll raw view until completion, then clear all
  task finish_op(input logic [31:0] exp_raw);
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_RAW_EVENT_STATUS, 32'h0);
      n++;
    end while (rd[`EVT_OP_COMPLETE] !== 1'b1 && n < 40);
    check("raw events", exp_raw, rd);
    wr(`OFS_MASKED_EVENT_STATUS, 32'h0000_003F);
    rd_chk("raw cleared", `OFS_RAW_EVENT_STATUS, 32'h0);
  endtask : finish_op

  task chk_req(input int i, input logic [1:0] op, input logic [31:0] a, input logic [31:0] d);
    check("request op", {30'h0, op}, {30'h0, reqs[i][65:64]});
    check("request address", a, reqs[i][63:32]);
    check("request data", d, reqs[i][31:0]);
  endtask : chk_req

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h2;
    awake = 1'b1;
    check_pulse = 1'b0;
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd_chk("reset value", ofs[i], rst_val[i]);
    end
    wr(`OFS_ARRAY_SIZE, 32'h0);
    rd_chk("size", `OFS_ARRAY_SIZE, `VAL_ARRAY_SIZE);
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped data", 32'h0, rd);
    check("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");
    foreach (cfg_val[i]) begin
      wr(`OFS_VECTOR_VECTORS_TO_RAM_CONFIG, cfg_val[i]);
      rd_chk("config", `OFS_VECTOR_VECTORS_TO_RAM_CONFIG, cfg_val[i]);
      check("vector pins", {30'h0, cfg_val[i][1], cfg_val[i][3]},
            {30'h0, to_ram, to_nvm});
    end
    $display("test config done");
    wr(`OFS_PROGRAM_ADDRESS, 32'h0000_0100);
    wr(`OFS_PROGRAM_WORD_0, 32'h1234_5678);
    wr(`OFS_OPERATION_CODE, `OPC_WORD_PROGRAM);
    finish_op(32'h0000_0003);
    chk_req(0, OP_PROGRAM, 32'h0000_0100, 32'h1234_5678);
    rd_chk("address step", `OFS_PROGRAM_ADDRESS, 32'h0000_0101);
    $display("test word program done");
    lat <= 4'hF;
    wr(`OFS_OPERATION_CODE, `OPC_PAGE_ERASE);
    wr(`OFS_OPERATION_CODE, `OPC_FULL_ARRAY_ERASE);
    finish_op(32'h0000_0007);
    rd_chk("opcode kept", `OFS_OPERATION_CODE, `OPC_PAGE_ERASE);
    check("request count", 32'h2, 32'(reqs.size()));
    chk_req(1, OP_PAGE_ERASE, 32'h0000_0101, 32'hFFFF_FFFF);
    lat <= 4'h2;
    wr(`OFS_OPERATION_CODE, `OPC_FULL_ARRAY_ERASE);
    finish_op(32'h0000_0003);
    chk_req(2, OP_FULL_ERASE, 32'h0000_0101, 32'hFFFF_FFFF);
    rd_chk("address after erase", `OFS_PROGRAM_ADDRESS, 32'h0000_0101);
    $display("test erase done");
    wr(`OFS_EVENT_MASK, 32'h0000_0037);
    wr(`OFS_OPERATION_CODE, 32'h0000_0055);
    rd_chk("raw bad code", `OFS_RAW_EVENT_STATUS, 32'h0000_0008);
    rd_chk("masked bad code", `OFS_MASKED_EVENT_STATUS, 32'h0);
    wr(`OFS_EVENT_MASK, 32'h0000_003F);
    rd_chk("unmasked bad code", `OFS_MASKED_EVENT_STATUS, 32'h0000_0008);
    check("no launch", 32'h3, 32'(reqs.size()));
    wr(`OFS_MASKED_EVENT_STATUS, 32'h0000_0008);
    rd_chk("bad code cleared", `OFS_RAW_EVENT_STATUS, 32'h0);
    $display("test bad code done");
    wr(`OFS_PROGRAM_ADDRESS, 32'h0000_0200);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_PROGRAM_WORD_0 + 8'(4 * i), bw[i]);
      rd_chk("program word", `OFS_PROGRAM_WORD_0 + 8'(4 * i), bw[i]);
    end
    wr(`OFS_OPERATION_CODE, `OPC_MULTI_WORD_PROGRAM);
    finish_op(32'h0000_0003);
    check("burst count", 32'h6, 32'(reqs.size()));
    chk_req(3, OP_PROGRAM, 32'h0000_0200, bw[0]);
    chk_req(4, OP_PROGRAM, 32'h0000_0202, bw[2]);
    chk_req(5, OP_PROGRAM, 32'h0000_0203, bw[3]);
    rd_chk("burst address", `OFS_PROGRAM_ADDRESS, 32'h0000_0204);
    $display("test burst done");
    check_pulse <= 1'b1;
    @(posedge ref_clk);
    check_pulse <= 1'b0;
    awake <= 1'b0;
    rd_chk("array events", `OFS_MASKED_EVENT_STATUS, 32'h0000_0030);
    wr(`OFS_MASKED_EVENT_STATUS, 32'h0000_0030);
    rd_chk("array events cleared", `OFS_RAW_EVENT_STATUS, 32'h0);
    awake <= 1'b1;
    $display("test array events done");
    finish_test;
  end
endmodule : flash_ctrl_register_interface_test
`default_nettype wire
